// ### ssd_phy_debug_regs.sv
`include "ssd_map.svh"
`default_nettype none
module ssd_phy_debug_regs
    import ssd_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic CFG_REQ_I,
    input wire logic CFG_WR_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic CFG_ACK_O,
    output logic [31:0] CFG_RDATA_O,
    input wire logic SMB_REQ_I,
    input wire logic SMB_WR_I,
    input wire logic [7:0] SMB_ADDR_I,
    input wire logic [31:0] SMB_WDATA_I,
    output logic SMB_ACK_O,
    output logic [31:0] SMB_RDATA_O,
    input wire logic EE_LOAD_VALID_I,
    input wire logic [7:0] EE_LOAD_ADDR_I,
    input wire logic [31:0] EE_LOAD_DATA_I,
    input wire logic REFCLK_BUFFER_POWERDOWN_STRAP_I,
    input wire logic [8:0] OPMODE_PINS_I,
    input wire logic [11:0] LT_STATE_I,
    output logic [2:0] REFERENCE_CLOCK_OUTPUTS_EN_O
);
    // ------------------------------------------------------------------------
    // Pin synchronisers and strap capture
    // ------------------------------------------------------------------------
    logic [9:0] pin_s1_reg, pin_s2_reg;
    logic [1:0] settle_reg, settle_next;
    logic strap_done_reg, strap_done_next;

    // The synchronisers restart from the reset word, so the mode word keeps its reset value until the pins arrive.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            pin_s1_reg <= {1'b0, 9'(`SSD_OPMODE_RST)};
            pin_s2_reg <= {1'b0, 9'(`SSD_OPMODE_RST)};
        end else begin
            pin_s1_reg <= {REFCLK_BUFFER_POWERDOWN_STRAP_I, OPMODE_PINS_I};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [15:0] opmode_reg, opmode_next;
    logic [4:0] clkbuf_reg, clkbuf_next;
    logic [31:0] subsystem_device_ident_reg, subsystem_device_ident_next;
    logic [`SSD_DBG_CTL_MSB:0] dbg_ctl_reg, dbg_ctl_next;
    logic [2:0] refclk_en_reg, refclk_en_next;
    logic cfg_ack_reg, smb_ack_reg;
    ssd_word_t cfg_rdata_reg, cfg_rdata_next, smb_rdata_reg, smb_rdata_next;
    logic side_wr;
    logic [7:0] side_addr;
    logic [31:0] side_data;
    logic [7:0] rxeq;

    ssd_dbg_if dbg ();

    ssd_debug_capture u_capture (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .lt_state_i(LT_STATE_I),
        .dbg(dbg.ctl)
    );

    assign rxeq = IS_UPSTREAM ? `SSD_RXEQ_UP_RST : `SSD_RXEQ_DOWN_RST;

    // EEPROM auto-load takes precedence over a simultaneous SMBus write.
    always_comb begin
        side_wr = EE_LOAD_VALID_I || (SMB_REQ_I && SMB_WR_I);
        side_addr = EE_LOAD_VALID_I ? EE_LOAD_ADDR_I : SMB_ADDR_I;
        side_data = EE_LOAD_VALID_I ? EE_LOAD_DATA_I : SMB_WDATA_I;
    end

    function automatic ssd_word_t read_word(input logic [7:0] addr, input logic sideband);
        ssd_word_t w;
        w = 32'h0000_0000;
        if (addr == `SSD_OFF_PHY_LANE_DELTA) begin
            w = {`SSD_DELTA_RST, 8'h00, `SSD_LANE_MODE_RST};
        end else if (addr == `SSD_OFF_PHY_MARGIN_EQ) begin
            w = {8'h00, rxeq, `SSD_TX_MARGIN_RST};
        end else if (addr == `SSD_OFF_OPMODE_CLKBUF) begin
            w = {11'h000, clkbuf_reg, opmode_reg};
        end else if (addr == `SSD_OFF_DEBUG_CONTROL) begin
            w = {25'h0000000, dbg_ctl_reg};
        end else if (addr == `SSD_OFF_DEBUG_DATA) begin
            w = sideband ? dbg.rd_data : 32'h0000_0000;
        end else if (addr == `SSD_OFF_SUBSYSTEM_DEVICE_IDENT_CAP_HDR) begin
            w = {16'h0000, `SSD_CAP_NEXT_PTR, `SSD_CAP_ID};
        end else if (addr == `SSD_OFF_SUBSYSTEM_DEVICE_IDENT_VALUES) begin
            w = subsystem_device_ident_reg;
        end
        // The GPIO control word after the subsystem_ident_values lives outside this bank.
        return w;
    endfunction : read_word

    always_comb begin
        opmode_next = {7'h00, pin_s2_reg[8:0]};
        clkbuf_next = clkbuf_reg;
        subsystem_device_ident_next = subsystem_device_ident_reg;
        dbg_ctl_next = dbg_ctl_reg;
        settle_next = settle_reg;
        strap_done_next = strap_done_reg;
        if (!strap_done_reg) begin
            if (settle_reg == `SSD_STRAP_SETTLE) begin
                clkbuf_next[`SSD_REFCLK_BUFFER_POWERDOWN_STRAP_BIT] = pin_s2_reg[9];
                strap_done_next = 1'b1;
            end else begin
                settle_next = settle_reg + 2'h1;
            end
        end
        if (side_wr && side_addr == `SSD_OFF_OPMODE_CLKBUF) begin
            clkbuf_next = side_data[`SSD_CLKBUF_MSB:`SSD_CLKBUF_LSB];
        end
        if (side_wr && side_addr == `SSD_OFF_SUBSYSTEM_DEVICE_IDENT_VALUES) begin
            subsystem_device_ident_next = side_data;
        end
        // Configuration writes reach only the debug control register.
        if (SMB_REQ_I && SMB_WR_I && SMB_ADDR_I == `SSD_OFF_DEBUG_CONTROL) begin
            dbg_ctl_next = SMB_WDATA_I[`SSD_DBG_CTL_MSB:0];
        end else if (CFG_REQ_I && CFG_WR_I && CFG_ADDR_I == `SSD_OFF_DEBUG_CONTROL) begin
            dbg_ctl_next = CFG_WDATA_I[`SSD_DBG_CTL_MSB:0];
        end
        refclk_en_next = clkbuf_reg[`SSD_REFCLK_BUFFER_POWERDOWN_STRAP_BIT] ? 3'h0 : clkbuf_reg[2:0];
        cfg_rdata_next = (CFG_REQ_I && !CFG_WR_I) ? read_word(CFG_ADDR_I, 1'b0) : 32'h0000_0000;
        smb_rdata_next = (SMB_REQ_I && !SMB_WR_I) ? read_word(SMB_ADDR_I, 1'b1) : 32'h0000_0000;
    end

    assign dbg.port_sel = dbg_ctl_reg[`SSD_DBG_PORT_MSB:0];
    assign dbg.trig_sel = dbg_ctl_reg[`SSD_DBG_TRIG_MSB:`SSD_DBG_TRIG_LSB];
    assign dbg.clear = dbg_ctl_reg[`SSD_DBG_CLEAR_BIT];
    assign dbg.pop = SMB_REQ_I && !SMB_WR_I && SMB_ADDR_I == `SSD_OFF_DEBUG_DATA && !dbg.empty;

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            opmode_reg <= `SSD_OPMODE_RST;
            clkbuf_reg <= {1'b0, `SSD_CLKBUF_EN_RST};
            subsystem_device_ident_reg <= {`SSD_SUBSYSTEM_DEVICE_IDENT_RST, `SSD_SUBSYSTEM_VENDOR_IDENT_RST};
            dbg_ctl_reg <= `SSD_DEBUG_CTL_RST;
            settle_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            refclk_en_reg <= 3'h0;
            cfg_ack_reg <= 1'b0;
            smb_ack_reg <= 1'b0;
            cfg_rdata_reg <= 32'h0000_0000;
            smb_rdata_reg <= 32'h0000_0000;
        end else begin
            opmode_reg <= opmode_next;
            clkbuf_reg <= clkbuf_next;
            subsystem_device_ident_reg <= subsystem_device_ident_next;
            dbg_ctl_reg <= dbg_ctl_next;
            settle_reg <= settle_next;
            strap_done_reg <= strap_done_next;
            refclk_en_reg <= refclk_en_next;
            cfg_ack_reg <= CFG_REQ_I;
            smb_ack_reg <= SMB_REQ_I;
            cfg_rdata_reg <= cfg_rdata_next;
            smb_rdata_reg <= smb_rdata_next;
        end
    end

    assign CFG_ACK_O = cfg_ack_reg;
    assign CFG_RDATA_O = cfg_rdata_reg;
    assign SMB_ACK_O = smb_ack_reg;
    assign SMB_RDATA_O = smb_rdata_reg;
    assign REFERENCE_CLOCK_OUTPUTS_EN_O = refclk_en_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_cfg_read(logic [7:0] a);
        CFG_REQ_I && !CFG_WR_I && CFG_ADDR_I == a;
    endsequence

    sequence s_cfg_only_write(logic [7:0] a);
        CFG_REQ_I && CFG_WR_I && CFG_ADDR_I == a && !SMB_REQ_I && !EE_LOAD_VALID_I;
    endsequence

    a_opmode_after_reset: assert property ($past(RST_I) |-> opmode_reg == `SSD_OPMODE_RST)
        else $error("Operation mode word wrong after reset.");
    a_refclk_powerdown: assert property (clkbuf_reg[`SSD_REFCLK_BUFFER_POWERDOWN_STRAP_BIT]
        |=> REFERENCE_CLOCK_OUTPUTS_EN_O == 3'h0)
        else $error("Reference clocks not disabled by powerdown bit.");
    a_refclk_enables: assert property (!clkbuf_reg[`SSD_REFCLK_BUFFER_POWERDOWN_STRAP_BIT]
        |=> REFERENCE_CLOCK_OUTPUTS_EN_O == $past(clkbuf_reg[2:0]))
        else $error("Reference clock enables do not follow bits 18:16.");
    a_clkbuf_cfg_ignored: assert property (s_cfg_only_write(`SSD_OFF_OPMODE_CLKBUF) ##0 strap_done_reg
        |=> $stable(clkbuf_reg))
        else $error("Configuration write changed clock buffer control.");
    a_debug_data_cfg_zero: assert property (s_cfg_read(`SSD_OFF_DEBUG_DATA) |=> CFG_RDATA_O == 32'h0000_0000)
        else $error("Debug data visible to configuration read.");
    a_cap_header_value: assert property (s_cfg_read(`SSD_OFF_SUBSYSTEM_DEVICE_IDENT_CAP_HDR) ##1 CFG_ACK_O
        |-> CFG_RDATA_O == {16'h0000, `SSD_CAP_NEXT_PTR, `SSD_CAP_ID})
        else $error("Capability header value wrong.");
    a_subsystem_device_ident_cfg_ignored: assert property (s_cfg_only_write(`SSD_OFF_SUBSYSTEM_DEVICE_IDENT_VALUES) |=> $stable(subsystem_device_ident_reg))
        else $error("Configuration write changed subsystem_ident_values.");
    a_phy3_value: assert property (s_cfg_read(`SSD_OFF_PHY_LANE_DELTA)
        |=> CFG_RDATA_O == {`SSD_DELTA_RST, 8'h00, `SSD_LANE_MODE_RST})
        else $error("Phy_lane_and_delta_params value wrong.");
    a_gpio_slot_empty: assert property (CFG_REQ_I && !CFG_WR_I && CFG_ADDR_I > `SSD_OFF_SUBSYSTEM_DEVICE_IDENT_VALUES
        |=> CFG_RDATA_O == 32'h0000_0000)
        else $error("Address beyond subsystem_ident_values answered from this bank.");
    a_debug_ctl_write: assert property (s_cfg_only_write(`SSD_OFF_DEBUG_CONTROL)
        |=> dbg_ctl_reg == $past(CFG_WDATA_I[`SSD_DBG_CTL_MSB:0]))
        else $error("Debug control write not stored.");
endmodule : ssd_phy_debug_regs
`default_nettype wire

// ### ssd_map.svh
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SSD_OFF_PHY_LANE_DELTA 8'h90
`define SSD_OFF_PHY_MARGIN_EQ 8'h94
`define SSD_OFF_OPMODE_CLKBUF 8'h98
`define SSD_OFF_DEBUG_CONTROL 8'h9C
`define SSD_OFF_DEBUG_DATA 8'hAC
`define SSD_OFF_SUBSYSTEM_DEVICE_IDENT_CAP_HDR 8'hB0
`define SSD_OFF_SUBSYSTEM_DEVICE_IDENT_VALUES 8'hB4

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define SSD_LANE_MODE_RST 7'h00
`define SSD_DELTA_RST 17'h00001
`define SSD_TX_MARGIN_RST 16'h116B
`define SSD_RXEQ_UP_RST 8'h86
`define SSD_RXEQ_DOWN_RST 8'h00
`define SSD_OPMODE_RST 16'h0102
`define SSD_CLKBUF_EN_RST 4'hF
`define SSD_CAP_ID 8'h0D
`define SSD_CAP_NEXT_PTR 8'hC0
`define SSD_SUBSYSTEM_VENDOR_IDENT_RST 16'h0000
`define SSD_SUBSYSTEM_DEVICE_IDENT_RST 16'h0000
`define SSD_DEBUG_CTL_RST 7'h00
`define SSD_STRAP_SETTLE 2'h2
`define SSD_PORT_COUNT 3
`define SSD_NO_PORT 2'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSD_CLKBUF_LSB 16
`define SSD_CLKBUF_MSB 20
`define SSD_REFCLK_BUFFER_POWERDOWN_STRAP_BIT 4
`define SSD_DBG_PORT_MSB 1
`define SSD_DBG_TRIG_LSB 2
`define SSD_DBG_TRIG_MSB 5
`define SSD_DBG_CLEAR_BIT 6
`define SSD_DBG_CTL_MSB 6

// ----------------------------------------------------------------------------
// Debug capture buffer
// ----------------------------------------------------------------------------
`define SSD_DBG_DEPTH 16
`define SSD_DBG_AW 4

`endif

// ### ssd_pkg.sv
`default_nettype none
package ssd_pkg;
    typedef enum logic [3:0] {
        SSD_LT_NONE = 4'h0,
        SSD_LT_DETECT = 4'h1,
        SSD_LT_POLLING = 4'h2,
        SSD_LT_CONFIG = 4'h3,
        SSD_LT_L0 = 4'h4,
        SSD_LT_L0S = 4'h5,
        SSD_LT_L1 = 4'h6,
        SSD_LT_L2 = 4'h7,
        SSD_LT_DISABLE = 4'h8,
        SSD_LT_HOT_RESET = 4'h9,
        SSD_LT_LOOPBACK = 4'hA,
        SSD_LT_RECOVERY = 4'hB
    } ssd_ltssm_e;

    typedef enum logic [1:0] {
        SSD_CAP_IDLE = 2'h0,
        SSD_CAP_ARMED = 2'h1,
        SSD_CAP_RUN = 2'h3,
        SSD_CAP_FULL = 2'h2
    } ssd_cap_state_e;

    typedef logic [31:0] ssd_word_t;
endpackage : ssd_pkg
`default_nettype wire

// ### ssd_dbg_if.sv
`default_nettype none
interface ssd_dbg_if;
    logic [1:0] port_sel;
    logic [3:0] trig_sel;
    logic clear;
    logic pop;
    logic empty;
    logic [31:0] rd_data;
    modport ctl (output port_sel, output trig_sel, output clear, output pop, input empty, input rd_data);
    modport cap (input port_sel, input trig_sel, input clear, input pop, output empty, output rd_data);
endinterface : ssd_dbg_if
`default_nettype wire

// ### ssd_debug_capture.sv
`include "ssd_map.svh"
`default_nettype none
module ssd_debug_capture
    import ssd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] lt_state_i,
    ssd_dbg_if.cap dbg
);
    // ------------------------------------------------------------------------
    // Capture state
    // ------------------------------------------------------------------------
    ssd_word_t mem [0:`SSD_DBG_DEPTH-1];
    ssd_cap_state_e state_reg, state_next;
    logic [`SSD_DBG_AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [3:0] last_reg, last_next;
    logic [27:0] stamp_reg, stamp_next;
    logic [3:0] cur;
    logic trig_ok, hit, full, wr_en;

    assign cur = (dbg.port_sel == `SSD_NO_PORT) ? 4'h0 : lt_state_i[dbg.port_sel*4 +: 4];
    assign trig_ok = (dbg.trig_sel >= SSD_LT_DETECT) && (dbg.trig_sel <= SSD_LT_RECOVERY)
                     && (dbg.port_sel != `SSD_NO_PORT);
    assign hit = trig_ok && (cur == dbg.trig_sel);
    assign full = (wr_ptr_reg - rd_ptr_reg) == (`SSD_DBG_AW+1)'(`SSD_DBG_DEPTH);
    assign dbg.empty = (wr_ptr_reg == rd_ptr_reg);
    assign dbg.rd_data = dbg.empty ? 32'h0000_0000 : mem[rd_ptr_reg[`SSD_DBG_AW-1:0]];

    always_comb begin
        state_next = state_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        last_next = cur;
        stamp_next = stamp_reg + 28'h0000001;
        wr_en = 1'b0;
        case (state_reg)
            SSD_CAP_IDLE: begin
                if (trig_ok) begin
                    state_next = SSD_CAP_ARMED;
                end
            end
            SSD_CAP_ARMED: begin
                if (!trig_ok) begin
                    state_next = SSD_CAP_IDLE;
                end else if (hit) begin
                    wr_en = 1'b1;
                    state_next = SSD_CAP_RUN;
                end
            end
            SSD_CAP_RUN: begin
                if (full) begin
                    state_next = SSD_CAP_FULL;
                end else if (cur != last_reg) begin
                    wr_en = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (wr_en) begin
            wr_ptr_next = wr_ptr_reg + 5'h01;
        end
        if (dbg.pop && !dbg.empty) begin
            rd_ptr_next = rd_ptr_reg + 5'h01;
        end
        if (dbg.clear) begin
            state_next = SSD_CAP_IDLE;
            wr_ptr_next = 5'h00;
            rd_ptr_next = 5'h00;
            wr_en = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SSD_CAP_IDLE;
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            last_reg <= 4'h0;
            stamp_reg <= 28'h0000000;
        end else begin
            state_reg <= state_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            last_reg <= last_next;
            stamp_reg <= stamp_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[wr_ptr_reg[`SSD_DBG_AW-1:0]] <= {stamp_reg, cur};
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_clear_empties_buffer: assert property (dbg.clear |=> dbg.empty && state_reg == SSD_CAP_IDLE)
        else $error("Debug clear did not empty the buffer.");
    a_trigger_starts_capture: assert property (state_reg == SSD_CAP_ARMED && hit && !dbg.clear
        |=> state_reg == SSD_CAP_RUN && wr_ptr_reg == $past(wr_ptr_reg) + 5'h01)
        else $error("Trigger state hit did not start capture.");
    a_reserved_no_trigger: assert property (!trig_ok && state_reg != SSD_CAP_RUN
        |=> $stable(wr_ptr_reg) || $past(dbg.clear))
        else $error("Capture advanced with a reserved trigger code.");
endmodule : ssd_debug_capture
`default_nettype wire

// ### ssd_eeprom_model.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Auto-load source that streams a short image into the bank
// ----------------------------------------------------------------------------
module ssd_eeprom_model (
    input wire logic clk_i,
    input wire logic start_i,
    output logic valid_o,
    output logic [7:0] addr_o,
    output logic [31:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] img_addr [0:1] = '{8'hB4, 8'h98};
    logic [31:0] img_data [0:1] = '{32'hBEEF1234, 32'h00060000};
    logic [1:0] idx_reg = 2'h3;
    logic [31:0] idle_pat = 32'hA5A5A5A5;

    always @(posedge clk_i) begin
        idle_pat <= ~idle_pat;
        if (start_i) begin
            idx_reg <= 2'h0;
        end else if (idx_reg != 2'h3) begin
            idx_reg <= idx_reg + 2'h1;
        end
    end

    // Outside a load the bus carries a toggling pattern, never the last word.
    always_comb begin
        valid_o = (idx_reg < 2'h2);
        addr_o = valid_o ? img_addr[idx_reg[0]] : idle_pat[7:0];
        data_o = valid_o ? img_data[idx_reg[0]] : idle_pat;
    end
endmodule : ssd_eeprom_model
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_req = 1'b0, cfg_wr = 1'b0, smb_req = 1'b0, smb_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00, smb_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0, smb_wdata = 32'h0;
    logic cfg_ack, smb_ack, ee_valid, ee_start = 1'b0, strap = 1'b0;
    logic [31:0] cfg_rdata, smb_rdata, ee_data;
    logic [7:0] ee_addr;
    logic [8:0] pins = 9'h102;
    logic [11:0] lt = 12'h000;
    logic [2:0] clk_en;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] reg_addr [0:6] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hB0, 8'hB4, 8'hB8};
    logic [31:0] reg_exp [0:6] = '{32'h00008000, 32'h0086116B, 32'h000F0102, 32'h0, 32'h0000C00D, 32'h0, 32'h0};

    ssd_phy_debug_regs #(.IS_UPSTREAM(1'b1)) ssd_phy_debug_regs_inst (
        .CORE_CLK_I(clk), .RST_I(rst),
        .CFG_REQ_I(cfg_req), .CFG_WR_I(cfg_wr), .CFG_ADDR_I(cfg_addr), .CFG_WDATA_I(cfg_wdata),
        .CFG_ACK_O(cfg_ack), .CFG_RDATA_O(cfg_rdata),
        .SMB_REQ_I(smb_req), .SMB_WR_I(smb_wr), .SMB_ADDR_I(smb_addr), .SMB_WDATA_I(smb_wdata),
        .SMB_ACK_O(smb_ack), .SMB_RDATA_O(smb_rdata),
        .EE_LOAD_VALID_I(ee_valid), .EE_LOAD_ADDR_I(ee_addr), .EE_LOAD_DATA_I(ee_data),
        .REFCLK_BUFFER_POWERDOWN_STRAP_I(strap), .OPMODE_PINS_I(pins), .LT_STATE_I(lt),
        .REFERENCE_CLOCK_OUTPUTS_EN_O(clk_en)
    );

    ssd_eeprom_model ssd_eeprom_model_inst (
        .clk_i(clk), .start_i(ee_start), .valid_o(ee_valid), .addr_o(ee_addr), .data_o(ee_data)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One access: request held for one taking edge, answer sampled in the acknowledge cycle.
    task automatic bus_acc(input bit smb, input bit wr, input logic [7:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata);
        @(posedge clk);
        #1;
        if (smb) begin
            {smb_req, smb_wr, smb_addr, smb_wdata} = {1'b1, wr, addr, wdata};
        end else begin
            {cfg_req, cfg_wr, cfg_addr, cfg_wdata} = {1'b1, wr, addr, wdata};
        end
        @(posedge clk);
        #1;
        chk("ack", 32'h1, {31'h0, (smb ? smb_ack : cfg_ack)});
        rdata = smb ? smb_rdata : cfg_rdata;
        smb_req = 1'b0;
        cfg_req = 1'b0;
    endtask : bus_acc

    task automatic wr(input bit smb, input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        bus_acc(smb, 1'b1, addr, data, dummy);
    endtask : wr

    task automatic rd(input bit smb, input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask,
                      input string name);
        logic [31:0] got;
        bus_acc(smb, 1'b0, addr, 32'h0, got);
        chk(name, exp, got & mask);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task tally_and_finish;
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        logic [3:0] nx;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        wait_cyc(6);
        // --------------------------------------------------------------------
        // Reset values, then configuration writes that must change nothing except debug control
        // --------------------------------------------------------------------
        for (int i = 0; i < 7; i++) begin
            rd(1'b0, reg_addr[i], reg_exp[i], 32'hFFFFFFFF, "reset_value");
        end
        chk("clk_en", 32'h7, {29'h0, clk_en});
        for (int i = 0; i < 7; i++) begin
            if (i != 3) begin
                wr(1'b0, reg_addr[i], 32'hFFFFFFFF);
                rd(1'b0, reg_addr[i], reg_exp[i], 32'hFFFFFFFF, "ro_after_write");
            end
        end
        wr(1'b0, 8'h9C, 32'hFFFFFFFF);
        rd(1'b0, 8'h9C, 32'h0000007F, 32'hFFFFFFFF, "debug_ctl");
        wr(1'b0, 8'h9C, 32'h0);
        pins = 9'h0A5;
        wait_cyc(4);
        rd(1'b0, 8'h98, 32'h000F00A5, 32'hFFFFFFFF, "opmode_pins");
        // --------------------------------------------------------------------
        // Clock buffer control from the sideband and from auto-load
        // --------------------------------------------------------------------
        wr(1'b1, 8'h98, 32'h001A0000);
        wait_cyc(2);
        chk("clk_en_pd", 32'h0, {29'h0, clk_en});
        rd(1'b0, 8'h98, 32'h001A00A5, 32'hFFFFFFFF, "clkbuf_smb");
        wr(1'b1, 8'h98, 32'h00050000);
        wait_cyc(2);
        chk("clk_en_sel", 32'h5, {29'h0, clk_en});
        ee_start = 1'b1;
        wait_cyc(1);
        ee_start = 1'b0;
        wait_cyc(5);
        rd(1'b0, 8'hB4, 32'hBEEF1234, 32'hFFFFFFFF, "subsystem_device_ident_eeprom");
        rd(1'b0, 8'h98, 32'h000600A5, 32'hFFFFFFFF, "clkbuf_eeprom");
        chk("clk_en_ee", 32'h6, {29'h0, clk_en});
        wr(1'b1, 8'hB4, 32'h5A5AC3C3);
        rd(1'b0, 8'hB4, 32'h5A5AC3C3, 32'hFFFFFFFF, "subsystem_device_ident_smb");
        // --------------------------------------------------------------------
        // Debug capture for every trigger code
        // --------------------------------------------------------------------
        for (int c = 1; c <= 11; c++) begin
            lt = 12'h000;
            wr(1'b0, 8'h9C, 32'h40);
            wr(1'b0, 8'h9C, c << 2);
            lt = {8'h00, 4'(c)};
            wait_cyc(3);
            nx = (c == 11) ? 4'h1 : 4'(c + 1);
            lt = {8'h00, nx};
            wait_cyc(3);
            rd(1'b0, 8'hAC, 32'h0, 32'hFFFFFFFF, "data_cfg");
            rd(1'b1, 8'hAC, c, 32'hF, "trigger_word");
            rd(1'b1, 8'hAC, {28'h0, nx}, 32'hF, "change_word");
            rd(1'b1, 8'hAC, 32'h0, 32'hFFFFFFFF, "drained");
        end
        lt = 12'h000;
        wr(1'b0, 8'h9C, 32'h40);
        wr(1'b0, 8'h9C, 32'h30);
        lt = 12'h00C;
        wait_cyc(4);
        rd(1'b1, 8'hAC, 32'h0, 32'hFFFFFFFF, "reserved_code");
        lt = 12'h000;
        wr(1'b0, 8'h9C, 32'h40);
        wr(1'b0, 8'h9C, 32'h05);
        lt = 12'h001;
        wait_cyc(4);
        rd(1'b1, 8'hAC, 32'h0, 32'hFFFFFFFF, "other_port");
        lt = 12'h011;
        wait_cyc(4);
        rd(1'b1, 8'hAC, 32'h1, 32'hF, "port1_word");
        // A state change every cycle fills the buffer; capture must stop after sixteen words.
        lt = 12'h000;
        wr(1'b0, 8'h9C, 32'h40);
        wr(1'b0, 8'h9C, 32'h04);
        lt = 12'h001;
        wait_cyc(3);
        for (int k = 0; k < 24; k++) begin
            lt = (k % 2 == 0) ? 12'h002 : 12'h001;
            wait_cyc(1);
        end
        for (int k = 0; k < 17; k++) begin
            rd(1'b1, 8'hAC, (k < 16) ? k % 2 + 1 : 0, (k < 16) ? 32'hF : 32'hFFFFFFFF, "full_stop");
        end
        lt = 12'h000;
        wr(1'b1, 8'h9C, 32'h40);
        wr(1'b1, 8'h9C, 32'h04);
        lt = 12'h001;
        wait_cyc(3);
        lt = 12'h002;
        wait_cyc(3);
        wr(1'b0, 8'h9C, 32'h44);
        wait_cyc(2);
        rd(1'b1, 8'hAC, 32'h0, 32'hFFFFFFFF, "cleared");
        rd(1'b0, 8'h9C, 32'h44, 32'hFFFFFFFF, "clear_bit");
        // --------------------------------------------------------------------
        // Second reset with the powerdown strap high
        // --------------------------------------------------------------------
        strap = 1'b1;
        rst = 1'b1;
        wait_cyc(3);
        rst = 1'b0;
        wait_cyc(6);
        rd(1'b0, 8'h98, 32'h001F0000, 32'hFFFF0000, "strap_bit");
        rd(1'b0, 8'h9C, 32'h0, 32'hFFFFFFFF, "debug_ctl_reset");
        chk("clk_en_strap", 32'h0, {29'h0, clk_en});
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
